// *** bench/host_model.sv ***
`timescale 1ns/1ps
// ==========
// host side of the gain pins: serial master or parallel driver
module host_model (
  input wire logic clk,
  output logic cs_b0,
  output logic din_b1,
  output logic sclk_b2,
  output logic b3
);
  initial
  begin
    cs_b0 = 1'b1;
    din_b1 = 1'b0;
    sclk_b2 = 1'b0;
    b3 = 1'b0;
  end
  task automatic hold_cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : hold_cyc
  // n low bits of b, msb first; csl high keeps the device deselected
  task automatic frame(input logic [7:0] b, input int n, input logic csl);
    sclk_b2 <= 1'b0;
    hold_cyc(4);
    cs_b0 <= csl;
    for (int i = n - 1; i >= 0; i--)
    begin
      din_b1 <= b[i];
      hold_cyc(4);
      sclk_b2 <= 1'b1;
      hold_cyc(4);
      sclk_b2 <= 1'b0;
    end
    hold_cyc(4);
    cs_b0 <= 1'b1;
    // a released data line must not keep showing the last bit
    din_b1 <= ~din_b1;
    hold_cyc(8);
  endtask : frame
  task automatic par(input logic [3:0] c);
    {b3, sclk_b2, din_b1, cs_b0} <= c;
    hold_cyc(6);
  endtask : par
endmodule : host_model

// *** bench/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst_n, sel, hold, pdn, so, oe, amp, hw, sw;
  logic [3:0] code;
  logic [12:0] gain;
  wire cs, din, sck, b3h;
  int error_cnt = 0;
  int cmp_count = 0;
  // pin level from both drivers
  wire d3 = oe ? so : b3h;
  always #50 clk = ~clk;
  host_model host_model_inst (.clk(clk), .cs_b0(cs), .din_b1(din), .sclk_b2(sck), .b3(b3h));
  gain_ctrl_if gain_ctrl_if_inst (.clk(clk), .rst_n(rst_n), .interface_select(sel),
    .latch_hold_input(hold), .power_down_input(pdn), .select_or_bit0(cs),
    .serial_in_or_bit1(din), .clock_or_bit2(sck), .serial_out_or_bit3_in(d3),
    .serial_out_or_bit3_out(so), .serial_out_or_bit3_oe(oe), .gain_code(code),
    .gain(gain), .amp_enable(amp), .hw_shutdown(hw), .sw_shutdown(sw));
  // ==========
  // checking
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  function automatic logic [12:0] exp_gain(input logic [3:0] c);
    if (c == 4'h0)
      return 13'h0000;
    if (c > 4'hC)
      return 13'h1000;
    return 13'h0001 << (c - 4'h1);
  endfunction : exp_gain
  task automatic exp_code(input logic [3:0] c);
    chk("gain_code", 16'(c), 16'(code));
    chk("gain", 16'(exp_gain(c)), 16'(gain));
  endtask : exp_code
  task automatic complete_run();
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : complete_run
  // ==========
  // scenarios
  task automatic serial_load();
    host_model_inst.frame(8'hA5, 8, 1'b0);
    exp_code(4'h5);
    host_model_inst.frame(8'hC3, 8, 1'b0);
    exp_code(4'h3);
    chk("dout", 16'(1'b1), 16'(so));
    host_model_inst.hold_cyc(10);
    chk("dout_kept", 16'(1'b1), 16'(so));
    chk("dout_oe", 16'(1'b1), 16'(oe));
  endtask : serial_load
  task automatic short_zero();
    host_model_inst.frame(8'h00, 4, 1'b0);
    exp_code(4'h0);
    chk("dout_chain", 16'(1'b0), 16'(so));
    chk("sw_shutdown", 16'(1'b1), 16'(sw));
    chk("amp_enable", 16'(1'b0), 16'(amp));
  endtask : short_zero
  task automatic stray_clocks();
    host_model_inst.frame(8'hFF, 8, 1'b1);
    host_model_inst.frame(8'h00, 0, 1'b0);
    exp_code(4'h0);
  endtask : stray_clocks
  task automatic power_down();
    pdn <= 1'b1;
    host_model_inst.frame(8'h07, 8, 1'b0);
    exp_code(4'h0);
    chk("hw_shutdown", 16'(1'b1), 16'(hw));
    chk("amp_hw", 16'(1'b0), 16'(amp));
    pdn <= 1'b0;
    host_model_inst.frame(8'h87, 8, 1'b0);
    exp_code(4'h7);
    chk("amp_on", 16'(1'b1), 16'(amp));
    chk("dout_pd", 16'(1'b1), 16'(so));
  endtask : power_down
  // a second reset in mid-run must bring code, serial out and flags back
  task automatic reset_again();
    rst_n <= 1'b0;
    host_model_inst.hold_cyc(3);
    exp_code(4'h0);
    chk("dout_rst", 16'(1'b0), 16'(so));
    chk("oe_rst", 16'(1'b1), 16'(oe));
    chk("sw_rst", 16'(1'b1), 16'(sw));
    chk("amp_rst", 16'(1'b0), 16'(amp));
    rst_n <= 1'b1;
    host_model_inst.hold_cyc(6);
  endtask : reset_again
  task automatic parallel();
    sel <= 1'b1;
    host_model_inst.hold_cyc(6);
    chk("oe_par", 16'(1'b0), 16'(oe));
    for (int c = 0; c < 16; c++)
    begin
      host_model_inst.par(4'(c));
      exp_code(4'(c));
    end
    host_model_inst.par(4'h9);
    hold <= 1'b1;
    host_model_inst.hold_cyc(4);
    host_model_inst.par(4'h2);
    exp_code(4'h9);
    hold <= 1'b0;
    host_model_inst.hold_cyc(4);
    exp_code(4'h2);
  endtask : parallel
  initial
  begin
    rst_n = 1'b0;
    sel = 1'b0;
    hold = 1'b0;
    pdn = 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    host_model_inst.hold_cyc(6);
    serial_load();
    short_zero();
    stray_clocks();
    power_down();
    reset_again();
    parallel();
    complete_run();
  end
  initial
  begin
    #500000;
    error_cnt++;
    complete_run();
  end
endmodule : testbench

// *** hdl/gain_ctrl_if.sv ***
`timescale 1ns/1ps
// Summary of operation
// - select pin high picks parallel, low serial
// - pins map to gain code bits 0..3
// - hold low: parallel latch transparent
// - hold high: parallel code frozen
// - package without hold pin: transparent except in hw shutdown
// - bit3 pin output serial, input parallel
// - cs low: shift msb first on rising clock
// - serial out updates on falling clock
// - cs rising copies low nibble to latch
// - cs high: no shifting
// - serial out always driven in serial mode
// - serial out keeps level after cs rises
// - daisy chain: out feeds next in
// - code maps to gains 0..4096
// - power down pin high shuts device
// - hw shutdown disables interfaces and amplifier
// - code zero: software shutdown, interface alive
module gain_ctrl_if #(
  parameter bit HAS_HOLD_PIN = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic interface_select,
  input wire logic latch_hold_input,
  input wire logic power_down_input,
  input wire logic select_or_bit0,
  input wire logic serial_in_or_bit1,
  input wire logic clock_or_bit2,
  input wire logic serial_out_or_bit3_in,
  output logic serial_out_or_bit3_out,
  output logic serial_out_or_bit3_oe,
  output logic [gain_ctrl_pkg::CODE_W-1:0] gain_code,
  output logic [gain_ctrl_pkg::GAIN_W-1:0] gain,
  output logic amp_enable,
  output logic hw_shutdown,
  output logic sw_shutdown
);

  // ==========================================================
  // reset release and pin synchronisers
  typedef struct packed {
    logic [1:0] rst_pipe;
  } rst_state_t;

  rst_state_t rs_ff;
  rst_state_t nxt_rs;
  logic rst_sync_n;

  always_comb
  begin
    nxt_rs = rs_ff;
    nxt_rs.rst_pipe = {rs_ff.rst_pipe[0], 1'b1};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rs_ff <= '0;
    else
      rs_ff <= nxt_rs;
  end

  assign rst_sync_n = rs_ff.rst_pipe[1];

  localparam int NSYNC = 7;
  logic [NSYNC-1:0] raw_pins;
  logic [NSYNC-1:0] s_pins;
  gain_ctrl_pkg::pin_in_t pins;
  logic s_par_mode;
  logic s_hold;
  logic s_pwr_down;

  // hold pin absent: behaves as tied low
  assign raw_pins = {interface_select, latch_hold_input & HAS_HOLD_PIN,
    power_down_input, select_or_bit0, serial_in_or_bit1, clock_or_bit2,
    serial_out_or_bit3_in};

  sync_2ff #(
    .W(NSYNC)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_sync_n),
    .d(raw_pins),
    .q(s_pins)
  );

  assign s_par_mode = s_pins[6];
  assign s_hold = s_pins[5];
  assign s_pwr_down = s_pins[4];
  assign pins = gain_ctrl_pkg::pin_in_t'(s_pins[3:0]);

  // ==========================================================
  // serial and parallel gain state
  typedef struct packed {
    logic [gain_ctrl_pkg::SHIFT_W-1:0] shreg;
    logic [gain_ctrl_pkg::CODE_W-1:0] serial_code;
    logic [gain_ctrl_pkg::CODE_W-1:0] par_latch;
    logic sout;
    logic clk_prev;
    logic cs_prev;
  } core_state_t;

  core_state_t st_ff;
  core_state_t nxt_st;
  logic clk_rise;
  logic clk_fall;
  logic cs_rise;
  logic iface_on;
  logic [gain_ctrl_pkg::CODE_W-1:0] par_code;

  // hardware shutdown freezes both interfaces
  assign iface_on = !s_pwr_down;
  assign clk_rise = pins.clock_or_bit2 && !st_ff.clk_prev;
  assign clk_fall = !pins.clock_or_bit2 && st_ff.clk_prev;
  assign cs_rise = pins.select_or_bit0 && !st_ff.cs_prev;
  assign par_code = {pins.serial_out_or_bit3, pins.clock_or_bit2,
    pins.serial_in_or_bit1, pins.select_or_bit0};

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.clk_prev = pins.clock_or_bit2;
    nxt_st.cs_prev = pins.select_or_bit0;
    if (iface_on && !s_par_mode)
    begin
      // a clock already high when cs falls is not a rising edge; host keeps it low
      if (clk_rise && !pins.select_or_bit0)
        nxt_st.shreg = {st_ff.shreg[gain_ctrl_pkg::SHIFT_W-2:0], pins.serial_in_or_bit1};
      if (clk_fall && !pins.select_or_bit0)
        nxt_st.sout = st_ff.shreg[gain_ctrl_pkg::SHIFT_W-1];
      if (cs_rise)
        nxt_st.serial_code = st_ff.shreg[gain_ctrl_pkg::CODE_W-1:0];
    end
    if (iface_on && s_par_mode && !s_hold)
      nxt_st.par_latch = par_code;
  end

  // latch contents after power-up are reset to code zero
  always_ff @(posedge clk or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      st_ff.shreg <= gain_ctrl_pkg::SHIFT_RESET;
      st_ff.serial_code <= gain_ctrl_pkg::CODE_RESET;
      st_ff.par_latch <= gain_ctrl_pkg::CODE_RESET;
      st_ff.sout <= 1'b0;
      st_ff.clk_prev <= 1'b0;
      st_ff.cs_prev <= 1'b1;
    end
    else
      st_ff <= nxt_st;
  end

  // ==========================================================
  // gain selection and outputs
  logic [gain_ctrl_pkg::CODE_W-1:0] active_code;
  logic [gain_ctrl_pkg::GAIN_W-1:0] dec_gain;
  gain_ctrl_pkg::amp_ctrl_t amp;

  // transparent path bypasses the flop so the pins set gain directly
  always_comb
  begin
    if (s_par_mode)
      active_code = (s_hold || !iface_on) ? st_ff.par_latch : par_code;
    else
      active_code = st_ff.serial_code;
  end

  gain_decode u_dec (
    .code(active_code),
    .gain(dec_gain)
  );

  always_comb
  begin
    amp.hw_shutdown = s_pwr_down;
    amp.sw_shutdown = !s_pwr_down && (active_code == gain_ctrl_pkg::CODE_SHUTDOWN);
    amp.amp_enable = !amp.hw_shutdown && !amp.sw_shutdown;
    amp.gain = dec_gain;
  end

  assign gain_code = active_code;
  assign gain = amp.gain;
  assign amp_enable = amp.amp_enable;
  assign hw_shutdown = amp.hw_shutdown;
  assign sw_shutdown = amp.sw_shutdown;
  // driven whenever serial mode, released in parallel mode; level held across cs high
  assign serial_out_or_bit3_oe = !s_par_mode;
  assign serial_out_or_bit3_out = st_ff.sout;

  // ==========================================================
  // checks
  AST_SHIFT_ON_RISE: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (iface_on && !s_par_mode && clk_rise && !pins.select_or_bit0)
    |=> st_ff.shreg == {$past(st_ff.shreg[gain_ctrl_pkg::SHIFT_W-2:0]),
    $past(pins.serial_in_or_bit1)})
    else $error("shift register missed a rising clock");

  AST_NO_SHIFT_CS_HIGH: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (pins.select_or_bit0 && !s_par_mode) |=> $stable(st_ff.shreg))
    else $error("shift while chip select high");

  AST_OUT_ON_FALL: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (iface_on && !s_par_mode && clk_fall && !pins.select_or_bit0)
    |=> serial_out_or_bit3_out == $past(st_ff.shreg[gain_ctrl_pkg::SHIFT_W-1]))
    else $error("serial out not updated on falling clock");

  AST_CS_LOAD: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (iface_on && !s_par_mode && cs_rise)
    |=> gain_code == $past(st_ff.shreg[gain_ctrl_pkg::CODE_W-1:0]))
    else $error("low nibble not loaded on chip select rise");

  AST_OUT_HOLD: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (pins.select_or_bit0 && $past(pins.select_or_bit0)) |-> $stable(serial_out_or_bit3_out))
    else $error("serial out changed while chip select high");

  AST_OE_SERIAL: assert property (@(posedge clk) disable iff (!rst_sync_n)
    serial_out_or_bit3_oe == !s_par_mode)
    else $error("serial out enable wrong for mode");

  AST_PAR_THRU: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (s_par_mode && !s_hold && iface_on) |-> gain_code == par_code)
    else $error("parallel code not transparent");

  AST_PAR_HOLD: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (s_par_mode && s_hold && $past(s_par_mode) && $past(s_hold)) |-> $stable(gain_code))
    else $error("held parallel code changed");

  AST_SW_POWER_DOWN_INPUT: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (!s_pwr_down && gain_code == gain_ctrl_pkg::CODE_SHUTDOWN)
    |-> (!amp_enable && sw_shutdown && gain == '0))
    else $error("code zero did not shut amplifier");

  AST_HW_POWER_DOWN_INPUT: assert property (@(posedge clk) disable iff (!rst_sync_n)
    s_pwr_down |-> (!amp_enable && hw_shutdown) ##1 $stable(st_ff.shreg))
    else $error("hardware shutdown left logic running");

  // ==========================================================
  // checks on mode gating, shutdown and the gain map
  // idle paths are watched too, so a stray enable shows up as a change

  AST_PAR_NO_SHIFT: assert property (@(posedge clk) disable iff (!rst_sync_n)
    s_par_mode
    |=> $stable(st_ff.shreg))
    else $error("shift register moved in parallel mode");

  AST_PAR_KEEPS_SERIAL: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (s_par_mode || !iface_on)
    |=> $stable(st_ff.serial_code))
    else $error("serial code changed outside serial mode");

  AST_SERIAL_KEEPS_PAR: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !s_par_mode
    |=> $stable(st_ff.par_latch))
    else $error("parallel latch changed in serial mode");

  AST_SERIAL_CODE_HOLD: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (!s_par_mode && !$past(s_par_mode) && !$past(cs_rise))
    |-> $stable(gain_code))
    else $error("serial gain code changed without chip select rise");

  AST_OUT_IDLE: assert property (@(posedge clk) disable iff (!rst_sync_n)
    !(iface_on && !s_par_mode && clk_fall && !pins.select_or_bit0)
    |=> $stable(serial_out_or_bit3_out))
    else $error("serial out changed without a falling clock");

  AST_HW_OUT_FROZEN: assert property (@(posedge clk) disable iff (!rst_sync_n)
    s_pwr_down
    |=> $stable(serial_out_or_bit3_out))
    else $error("serial out moved in hardware shutdown");

  AST_HW_CODE_FROZEN: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (s_pwr_down && $past(s_pwr_down) && (s_par_mode == $past(s_par_mode)))
    |-> $stable(gain_code))
    else $error("gain code moved in hardware shutdown");

  AST_HW_FLAGS: assert property (@(posedge clk) disable iff (!rst_sync_n)
    s_pwr_down
    |-> (hw_shutdown && !sw_shutdown))
    else $error("hardware shutdown flags wrong");

  AST_AMP_ON: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (!s_pwr_down && gain_code != gain_ctrl_pkg::CODE_SHUTDOWN)
    |-> (amp_enable && !sw_shutdown && !hw_shutdown))
    else $error("amplifier off with a nonzero code");

  AST_GAIN_ZERO: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (gain_code == gain_ctrl_pkg::CODE_SHUTDOWN)
    |-> (gain == '0))
    else $error("code zero gave a nonzero gain");

  AST_GAIN_TOP: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (gain_code > gain_ctrl_pkg::CODE_MAX_STEP)
    |-> (gain == gain_ctrl_pkg::GAIN_TOP))
    else $error("top codes did not give the top gain");

  AST_GAIN_ONEHOT: assert property (@(posedge clk) disable iff (!rst_sync_n)
    (gain_code != gain_ctrl_pkg::CODE_SHUTDOWN)
    |-> $onehot(gain))
    else $error("nonzero code gave a gain that is not a power of two");

endmodule : gain_ctrl_if

// *** hdl/gain_ctrl_pkg.sv ***
package gain_ctrl_pkg;

  localparam int CODE_W = 4;
  localparam int SHIFT_W = 8;
  localparam int GAIN_W = 13;
  localparam logic [CODE_W-1:0] CODE_SHUTDOWN = 4'h0;
  localparam logic [CODE_W-1:0] CODE_MAX_STEP = 4'hC;
  localparam logic [GAIN_W-1:0] GAIN_TOP = 13'h1000;
  localparam logic [GAIN_W-1:0] GAIN_ONE = 13'h0001;
  localparam logic [SHIFT_W-1:0] SHIFT_RESET = 8'h00;
  localparam logic [CODE_W-1:0] CODE_RESET = 4'h0;

  typedef struct packed {
    logic select_or_bit0;
    logic serial_in_or_bit1;
    logic clock_or_bit2;
    logic serial_out_or_bit3;
  } pin_in_t;

  typedef struct packed {
    logic [GAIN_W-1:0] gain;
    logic amp_enable;
    logic hw_shutdown;
    logic sw_shutdown;
  } amp_ctrl_t;

endpackage : gain_ctrl_pkg

// *** hdl/gain_decode.sv ***
`timescale 1ns/1ps
// code to gain: 0 -> 0, 1..12 -> 2^(code-1), 13..15 -> 4096
module gain_decode (
  input wire logic [gain_ctrl_pkg::CODE_W-1:0] code,
  output logic [gain_ctrl_pkg::GAIN_W-1:0] gain
);

  always_comb
  begin
    if (code == gain_ctrl_pkg::CODE_SHUTDOWN)
      gain = '0;
    else if (code > gain_ctrl_pkg::CODE_MAX_STEP)
      gain = gain_ctrl_pkg::GAIN_TOP;
    else
      gain = gain_ctrl_pkg::GAIN_ONE << (code - 4'h1);
  end

endmodule : gain_decode

// *** hdl/sync_2ff.sv ***
`timescale 1ns/1ps
// two-stage synchroniser per bit; first stage is read only by the second
module sync_2ff #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_state_t;

  sync_state_t st_ff;
  sync_state_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.meta = d;
    nxt_st.stable = st_ff.meta;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign q = st_ff.stable;

endmodule : sync_2ff
